// [hw/wdtc_top.sv]
// Watchdog control and time-out logic with an APB register slave.
// Assumes wdt_osc is the free-running watchdog oscillator, a level that
// toggles at the oscillator rate and is sampled here on pclk.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Writing one to the enable bit turns the watchdog on, writing zero turns it off only when unlocked.
// - A clear of the enable bit is ignored unless the turn-off unlock bit currently reads one.
// - A zero written to the enable bit within four clock cycles of the unlock write disables the watchdog.
// - The three-bit prescale field at bits 2:0 selects the time-out period while enabled.
// - Codes 000 to 111 select 16,384 to 2,097,152 oscillator cycles, doubling per code.
// - The turn-off unlock bit clears itself four clock cycles after being written to one.
// - If the period elapses without a restart the block issues a device reset request.
// - The count returns to zero on disable, on a restart command and on any chip reset.
// - Control register bits 7 to 5 always read as zero.
module wdtc_top
#(
   parameter int unsigned BASE_COUNT = wdtc_pkg::BASE_TIMEOUT
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        wdt_osc,
   output logic             watchdog_reset_req,
   output logic             irq
);

   function automatic logic [wdtc_pkg::COUNT_W-1:0] period_of(input logic [2:0] code);
      logic [wdtc_pkg::COUNT_W-1:0] base;
      base = wdtc_pkg::COUNT_W'(BASE_COUNT);
      return base << code;
   endfunction

   wdtc_pkg::wdtc_control_t       ctrl;
   wdtc_pkg::wdtc_unlock_t        unlock;
   logic [wdtc_pkg::COUNT_W-1:0]  count;
   logic                          osc_meta;
   logic                          osc_sync;
   logic                          osc_prev;
   logic                          status_timeout;
   logic                          int_en;

   // Bus decode.
   wire        setup_phase = psel & ~penable;
   wire        wr_access   = psel & penable & pwrite;
   wire        hit_control = (paddr == wdtc_pkg::ADDR_CONTROL);
   wire        hit_status  = (paddr == wdtc_pkg::ADDR_STATUS);
   wire        hit_int_en  = (paddr == wdtc_pkg::ADDR_INT_EN);
   wire        hit_int_clr = (paddr == wdtc_pkg::ADDR_INT_CLR);
   wire        hit_restart = (paddr == wdtc_pkg::ADDR_RESTART);
   wire        mapped      = hit_control | hit_status | hit_int_en | hit_int_clr | hit_restart;
   wire        wr_control  = wr_access & hit_control;
   wire        wr_int_en   = wr_access & hit_int_en;
   wire        wr_int_clr  = wr_access & hit_int_clr;
   wire        wr_restart  = wr_access & hit_restart;

   wire        wr_en_bit   = pwdata[wdtc_pkg::BIT_ENABLE];
   wire        wr_toe_bit  = pwdata[wdtc_pkg::BIT_UNLOCK];
   wire [2:0]  wr_prescale = pwdata[wdtc_pkg::PRESCALE_LSB +: wdtc_pkg::PRESCALE_W];

   // Unlock write: both bits as one in a single write.
   wire        unlock_wr   = wr_control & wr_en_bit & wr_toe_bit;
   // A clear succeeds only while the window from a prior unlock write is open.
   wire        disable_wr  = wr_control & ~wr_en_bit & unlock.active;
   wire        next_enable = disable_wr ? 1'b0 :
                             (wr_control & wr_en_bit) ? 1'b1 : ctrl.watchdog_enable_bit;
   // Next state of the window, kept in the control word so the bit reads from a flop.
   wire        window_next = unlock_wr | (unlock.active & ~disable_wr
                             & (unlock.wait_cycles != 3'h1));

   // Oscillator rising edge, taken only from the second stage onward.
   wire        osc_tick    = osc_sync & ~osc_prev;
   wire [wdtc_pkg::COUNT_W-1:0] period = period_of(ctrl.prescale);
   // A shorter period chosen mid-count expires at the next tick instead of after a wrap.
   wire        expire      = ctrl.watchdog_enable_bit & osc_tick
                             & (count >= period - wdtc_pkg::COUNT_W'(1));
   wire        count_clear = ~ctrl.watchdog_enable_bit | wr_restart | expire;

   wire [7:0]  control_rd  = {3'h0, ctrl.turn_off_unlock, ctrl.watchdog_enable_bit,
                              ctrl.prescale};
   wire [31:0] next_prdata = hit_control ? {24'h0, control_rd} :
                             hit_status  ? {31'h0, status_timeout} :
                             hit_int_en  ? {31'h0, int_en} : 32'h0;

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign irq     = status_timeout & int_en;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl.reserved            <= 3'h0;
         ctrl.turn_off_unlock     <= 1'b0;
         ctrl.watchdog_enable_bit <= wdtc_pkg::ENABLE_RST;
         ctrl.prescale            <= wdtc_pkg::PRESCALE_RST;
      end
      else
      begin
         ctrl.watchdog_enable_bit <= next_enable;
         ctrl.turn_off_unlock     <= window_next;
         if (wr_control)
         begin
            ctrl.prescale <= wr_prescale;
         end
      end
   end

   // The window is reloaded by each unlock write and closes by itself.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         unlock <= '0;
      end
      else if (unlock_wr)
      begin
         unlock.active      <= 1'b1;
         unlock.wait_cycles <= wdtc_pkg::UNLOCK_CYCLES;
      end
      else if (disable_wr || unlock.wait_cycles == 3'h1)
      begin
         unlock <= '0;
      end
      else if (unlock.active)
      begin
         unlock.wait_cycles <= unlock.wait_cycles - 3'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
         osc_prev <= 1'b0;
      end
      else
      begin
         osc_meta <= wdt_osc;
         osc_sync <= osc_meta;
         osc_prev <= osc_sync;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count <= '0;
      end
      else if (count_clear)
      begin
         count <= '0;
      end
      else if (osc_tick)
      begin
         count <= count + wdtc_pkg::COUNT_W'(1);
      end
   end

   // One-cycle reset request; the chip reset generator stretches it.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         watchdog_reset_req <= 1'b0;
      end
      else
      begin
         watchdog_reset_req <= expire;
      end
   end

   // A time-out in the same cycle as a clear keeps the flag set.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status_timeout <= 1'b0;
         int_en         <= wdtc_pkg::INT_EN_RST;
      end
      else
      begin
         if (expire)
         begin
            status_timeout <= 1'b1;
         end
         else if (wr_int_clr && pwdata[wdtc_pkg::BIT_TIMEOUT])
         begin
            status_timeout <= 1'b0;
         end
         if (wr_int_en)
         begin
            int_en <= pwdata[wdtc_pkg::BIT_TIMEOUT];
         end
      end
   end

   // Read data is loaded in the setup cycle so it comes from a flop.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0;
      end
      else if (setup_phase)
      begin
         prdata <= pwrite ? 32'h0 : next_prdata;
      end
   end

endmodule // wdtc_top

`default_nettype wire

// [hw/wdtc_pkg.sv]
// Package for the watchdog control and time-out block.
// Assumes an APB3 register bus with 32-bit data and a single system clock.
`default_nettype none
package wdtc_pkg;

   // Register byte addresses on the APB bus.
   localparam logic [7:0] ADDR_CONTROL  = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_INT_EN   = 8'h08;
   localparam logic [7:0] ADDR_INT_CLR  = 8'h0c;
   localparam logic [7:0] ADDR_RESTART  = 8'h10;

   // Control register field positions.
   localparam int unsigned BIT_UNLOCK   = 4;
   localparam int unsigned BIT_ENABLE   = 3;
   localparam int unsigned PRESCALE_LSB = 0;
   localparam int unsigned PRESCALE_W   = 3;

   // Status, enable and clear registers share this layout.
   localparam int unsigned BIT_TIMEOUT  = 0;

   // Reset values.
   localparam logic [2:0] PRESCALE_RST = 3'h0;
   localparam logic       ENABLE_RST   = 1'b0;
   localparam logic       INT_EN_RST   = 1'b0;

   // Unlock window, in system clock cycles.
   localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

   // Shortest time-out in oscillator cycles; each prescale code doubles it.
   localparam int unsigned BASE_TIMEOUT = 16384;
   localparam int unsigned COUNT_W      = 22;

   typedef struct packed
   {
      logic [2:0] reserved;
      logic       turn_off_unlock;
      logic       watchdog_enable_bit;
      logic [2:0] prescale;
   } wdtc_control_t;

   typedef struct packed
   {
      logic [2:0] wait_cycles;
      logic       active;
   } wdtc_unlock_t;

endpackage : wdtc_pkg

`default_nettype wire

// [verif/wdtc_assertions.sv]
// Port checker for the watchdog control block.
// Assumes it is bound into wdtc_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module wdtc_assertions
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        wdt_osc,
   input wire logic        watchdog_reset_req,
   input wire logic        irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire        acc = psel && penable;
   wire        rd0 = acc && !pwrite && paddr == 8'h00;
   wire        unm = !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10});
   wire        unl = acc && pwrite && paddr == 8'h00 && pwdata[4] && pwdata[3];
   logic [2:0] since;
   // Saturates at seven so a read well past the window must show the bit clear.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         since <= 3'h7;
      else if (unl)
         since <= 3'h0;
      else if (since != 3'h7)
         since <= since + 3'h1;
   rsvd_zero_a: assert property (rd0 |-> prdata[7:5] == 3'h0)
      else $error("reserved bits set");
   unlock_clear_a: assert property (rd0 && since == 3'h7 |-> !prdata[4])
      else $error("unlock bit stuck");
   pulse_single_a: assert property (watchdog_reset_req |=> !watchdog_reset_req)
      else $error("reset request too long");
   irq_cause_a: assert property ($rose(irq) && !$past(acc && pwrite && paddr == 8'h08)
      |-> watchdog_reset_req)
      else $error("irq without time-out");
   irq_fall_a: assert property ($fell(irq) |-> $past(acc && pwrite && paddr[3]))
      else $error("irq fell unasked");
   unmapped_err_a: assert property (acc && unm |-> pslverr && prdata == 32'h0)
      else $error("unmapped access accepted");
   mapped_ok_a: assert property (acc && !unm |-> pready && !pslverr)
      else $error("mapped access refused");
   write_zero_a: assert property (acc && pwrite |-> prdata == 32'h0)
      else $error("read data on write");
endmodule // wdtc_assertions
bind wdtc_top wdtc_assertions i_wdtc_assertions (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .wdt_osc, .watchdog_reset_req, .irq);
`default_nettype wire

// [verif/wdtc_top_tb_top.sv]
// Self-checking bench for the watchdog control block.
// Assumes zero-wait APB answers and a slow oscillator level on wdt_osc.
`timescale 1ns/1ns
`default_nettype none
module wdtc_top_tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        wdt_osc = 1'b0;
   logic        watchdog_reset_req;
   logic        irq;
   logic [31:0] exp_q[$];
   logic [7:0]  r;
   int          n_errors = 0;
   int          total_checks = 0;
   int          n_pulse = 0;
   int          cyc = 0;
   always #25 pclk = ~pclk;
   wdtc_top #(.BASE_COUNT(4)) i_wdtc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .wdt_osc, .watchdog_reset_req, .irq);
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge pclk);
   endtask
   // The oscillator stays still between bursts so every tick is counted exactly.
   task automatic osc(int n);
      repeat (n)
      begin
         idle(4);
         wdt_osc <= 1'b1;
         idle(4);
         wdt_osc <= 1'b0;
      end
   endtask
   always @(posedge pclk)
   begin
      if (watchdog_reset_req === 1'b1)
         n_pulse++;
      if (psel && penable && !pwrite && pready && exp_q.size() > 0)
         chk("prdata", prdata, exp_q.pop_front());
   end
   // The ceiling is a few times the roughly nine thousand cycles the tests need.
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_errors++;
         complete_run();
      end
   end
   initial
   begin
      void'($urandom(32'h02f3311a));
      idle(20);
      presetn <= 1'b1;
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      rd(8'h14, 32'h0);
      r = 8'h0d | (8'($urandom()) & 8'he0);
      apb(1'b1, 8'h00, 32'(r));
      rd(8'h00, 32'h0d);
      apb(1'b1, 8'h00, 32'(r & 8'he0));
      rd(8'h00, 32'h08);
      $display("test control register done");
      for (int d = 0; d < 3; d++)
      begin
         apb(1'b1, 8'h00, 32'h08);
         apb(1'b1, 8'h10, 32'h0);
         apb(1'b1, 8'h00, 32'h18);
         idle(d);
         apb(1'b1, 8'h00, 32'h0);
         rd(8'h00, (d < 2) ? 32'h0 : 32'h08);
      end
      $display("test turn-off done");
      apb(1'b1, 8'h00, 32'h09);
      osc(7);
      apb(1'b1, 8'h10, 32'h0);
      osc(7);
      chk("restart", 32'(n_pulse), 32'h0);
      osc(1);
      idle(8);
      chk("pulse", 32'(n_pulse), 32'h1);
      apb(1'b1, 8'h0c, 32'h1);
      for (int p = 0; p < 8; p++)
      begin
         apb(1'b1, 8'h08, 32'(p % 2));
         apb(1'b1, 8'h00, 32'(8 | p));
         osc((4 << p) - 1);
         idle(8);
         chk("early", 32'(n_pulse), 32'(p + 1));
         osc(1);
         idle(8);
         chk("expiry", 32'(n_pulse), 32'(p + 2));
         chk("irq", 32'(irq), 32'(p % 2));
         rd(8'h04, 32'h1);
         apb(1'b1, 8'h0c, 32'h1);
         idle(2);
         chk("irq clear", 32'(irq), 32'h0);
         rd(8'h04, 32'h0);
      end
      $display("test time-outs done");
      idle(4);
      chk("pending reads", 32'(exp_q.size()), 32'h0);
      complete_run();
   end
endmodule // wdtc_top_tb_top
`default_nettype wire
